// >>> core/ast_defines.svh
// Timing, layout and code constants of the converter serial transfer sequencer.
// Assumes a 10 ns system clock on both ends; include by bare name.
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

`define AST_CLK_NS        10
`define AST_IOCLK_NS      160
`define AST_IOCLK_HALF    (`AST_IOCLK_NS / (2 * `AST_CLK_NS))

`define AST_CS_QUAL_NS    1425
`define AST_CS_ON_CYC     ((`AST_CS_QUAL_NS + `AST_CLK_NS - 1) / `AST_CLK_NS)
`define AST_CS_OFF_CYC    (`AST_CS_QUAL_NS / `AST_CLK_NS)
`define AST_SYNC_SLACK    4

`define AST_CONV_NS       21000
`define AST_CONV_CYC      (`AST_CONV_NS / `AST_CLK_NS)
`define AST_ABORT_NS      9000
`define AST_ABORT_CYC     (`AST_ABORT_NS / `AST_CLK_NS)

`define AST_LEN_PLAIN     5'h0A
`define AST_LEN_MIN       5'h0B
`define AST_LEN_MAX       5'h10
`define AST_ADDR_EDGE     5'h04
`define AST_CONV_EDGE     5'h0A
`define AST_LAST_SHIFT    5'h09

`define AST_TEST_MID      4'hB
`define AST_TEST_ZERO     4'hC
`define AST_TEST_FULL     4'hD
`define AST_CODE_MID      10'h200
`define AST_CODE_ZERO     10'h000
`define AST_CODE_FULL     10'h3FF
`define AST_CODE_RESET    10'h000

`endif

// >>> core/ast_pkg.sv
// Types shared by both ends of the converter serial link.
// Assumes nothing beyond the constants header.
package ast_pkg;

    typedef logic [9:0] ast_code_t;
    typedef logic [3:0] ast_chan_t;

    typedef enum logic [4:0] {
        AST_H_IDLE    = 5'h01,
        AST_H_WAITEOC = 5'h02,
        AST_H_SETUP   = 5'h04,
        AST_H_SHIFT   = 5'h08,
        AST_H_RELEASE = 5'h10
    } ast_host_st_t;

endpackage

// >>> core/ast_link_if.sv
// Four-wire serial link plus end-of-conversion flag between host and converter.
// Assumes the host makes the shift clock; the testbench joins both ends here.
`timescale 1ns/10ps
`default_nettype none

interface ast_link_if;

    logic cs_b;
    logic io_clk;
    logic addr;
    logic dout;
    logic dout_oe;
    logic eoc;

    modport dev
    (
        input  cs_b,
        input  io_clk,
        input  addr,
        output dout,
        output dout_oe,
        output eoc
    );

    modport host
    (
        output cs_b,
        output io_clk,
        output addr,
        input  dout,
        input  dout_oe,
        input  eoc
    );

endinterface

`default_nettype wire

// >>> core/ast_dev.sv
// Converter end: select filter, frame counting, acquisition, conversion, result shift-out.
// Assumes clk is the converter's own system clock and the host drives the link pins.
//
// Notes on behaviour
// R1: Ignore link until select stays low long.
// R2: Host waits select setup before shifting address.
// R3: Select high disables link within filter time.
// R4: Ten-clock frames work with select held low.
// R5: Select-framed transfers of eleven to sixteen clocks.
// R6: Short ten-clock unframed frames start after flag.
// R7: Eleventh rising edge precedes end of conversion.
// R8: Long unframed frames are exactly sixteen clocks.
// R9: Acquire channel during six shift periods.
// R10: Flag falls at tenth falling edge, rises done.
// R11: Three self-test addresses give fixed codes.
// R12: Early select fall aborts running conversion.
// R13: Address in, previous result out, MSB first.
`timescale 1ns/10ps
`default_nettype none
`include "ast_defines.svh"

module ast_dev
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    ast_link_if.dev                link,
    input  wire ast_pkg::ast_code_t sample_level,
    output logic                   sample_active,
    output ast_pkg::ast_chan_t     sample_chan,
    output logic                   conv_busy,
    output ast_pkg::ast_code_t     result,
    output logic                   result_valid
);

    logic               [3:0]  addr_sh_q;
    logic                      cs_s1_q;
    logic                      cs_s2_q;
    logic                      ck_s1_q;
    logic                      ck_s2_q;
    logic                      ck_s3_q;
    logic               [3:0]  as_s1_q;
    logic               [3:0]  as_s2_q;
    logic                      ck_rise;
    logic                      ck_fall;
    logic               [7:0]  flt_cnt_q;
    logic               [7:0]  flt_lim;
    logic                      sel_on_q;
    logic                      sel_on_prev_q;
    logic                      sel_start;
    logic               [4:0]  bit_cnt_q;
    logic                      acq_q;
    ast_pkg::ast_chan_t        chan_q;
    ast_pkg::ast_code_t        samp_q;
    logic                      conv_q;
    logic               [11:0] conv_cnt_q;
    logic                      conv_start;
    logic                      conv_done;
    logic                      conv_abort;
    logic                      eoc_q;
    ast_pkg::ast_code_t        result_q;
    logic                      result_valid_q;
    ast_pkg::ast_code_t        out_sh_q;

    function automatic ast_pkg::ast_code_t pick_code
    (
        input ast_pkg::ast_chan_t ch,
        input ast_pkg::ast_code_t lvl
    );
        case (ch)
            `AST_TEST_MID:
            begin
                pick_code = `AST_CODE_MID;
            end
            `AST_TEST_ZERO:
            begin
                pick_code = `AST_CODE_ZERO;
            end
            `AST_TEST_FULL:
            begin
                pick_code = `AST_CODE_FULL;
            end
            default:
            begin
                pick_code = lvl;
            end
        endcase
    endfunction

    // Address bits enter on the rising shift-clock edge in the link domain.
    always_ff @(posedge link.io_clk)
    begin
        addr_sh_q <= {addr_sh_q[2:0], link.addr}; // [R13]
    end

    // Pin and cross-domain synchronisers.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            as_s1_q <= 4'h0;
            as_s2_q <= 4'h0;
        end
        else
        begin
            cs_s1_q <= link.cs_b;
            cs_s2_q <= cs_s1_q;
            ck_s1_q <= link.io_clk;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            as_s1_q <= addr_sh_q;
            as_s2_q <= as_s1_q;
        end
    end

    assign ck_rise = ck_s2_q & ~ck_s3_q;
    assign ck_fall = ~ck_s2_q & ck_s3_q;

    // Select must hold its new level for the whole filter time to be believed.
    assign flt_lim = sel_on_q ? 8'(`AST_CS_OFF_CYC - 1) : 8'(`AST_CS_ON_CYC - 1);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            flt_cnt_q <= 8'h00;
            sel_on_q  <= 1'b0;
        end
        else if (cs_s2_q != sel_on_q)
        begin
            flt_cnt_q <= 8'h00;
        end
        else if (flt_cnt_q == flt_lim)
        begin
            flt_cnt_q <= 8'h00;
            sel_on_q  <= ~sel_on_q; // [R1] [R3]
        end
        else
        begin
            flt_cnt_q <= flt_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sel_on_prev_q <= 1'b0;
        end
        else
        begin
            sel_on_prev_q <= sel_on_q;
        end
    end

    assign sel_start = sel_on_q & ~sel_on_prev_q;

    // Frame position counts qualified rising shift-clock edges.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bit_cnt_q <= 5'h00;
        end
        else if (!sel_on_q)
        begin
            bit_cnt_q <= 5'h00; // [R1] [R3] [R5]
        end
        else if (conv_done && bit_cnt_q == `AST_LEN_PLAIN)
        begin
            bit_cnt_q <= 5'h00; // [R4] [R6]
        end
        else if (ck_fall && bit_cnt_q == `AST_LEN_MAX)
        begin
            bit_cnt_q <= 5'h00; // [R5] [R8]
        end
        else if (ck_rise && bit_cnt_q != `AST_LEN_MAX)
        begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    assign conv_start = sel_on_q & ck_fall & (bit_cnt_q == `AST_CONV_EDGE) & ~conv_q;

    // Acquisition runs from the fourth to the tenth falling edge.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            acq_q  <= 1'b0;
            chan_q <= 4'h0;
            samp_q <= `AST_CODE_RESET;
        end
        else if (sel_on_q && ck_fall && bit_cnt_q == `AST_ADDR_EDGE)
        begin
            acq_q  <= 1'b1; // [R9]
            chan_q <= as_s2_q; // [R13]
        end
        else if (conv_start)
        begin
            acq_q  <= 1'b0; // [R9]
            samp_q <= pick_code(chan_q, sample_level); // [R11]
        end
        else if (!sel_on_q)
        begin
            acq_q <= 1'b0;
        end
    end

    assign conv_done  = conv_q & (conv_cnt_q == 12'(`AST_CONV_CYC - 1));
    assign conv_abort = conv_q & sel_start & (conv_cnt_q < 12'(`AST_ABORT_CYC));

    // Conversion timer and end-of-conversion flag.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            conv_q     <= 1'b0;
            conv_cnt_q <= 12'h000;
            eoc_q      <= 1'b1;
        end
        else if (conv_start)
        begin
            conv_q     <= 1'b1;
            conv_cnt_q <= 12'h000;
            eoc_q      <= 1'b0; // [R10]
        end
        else if (conv_abort || conv_done)
        begin
            conv_q <= 1'b0; // [R12]
            eoc_q  <= 1'b1; // [R10]
        end
        else if (conv_q)
        begin
            conv_cnt_q <= conv_cnt_q + 12'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            result_q       <= `AST_CODE_RESET;
            result_valid_q <= 1'b0;
        end
        else
        begin
            result_valid_q <= conv_done;
            if (conv_done)
            begin
                result_q <= samp_q;
            end
        end
    end

    // Result leaves MSB first; falling edges one to nine each bring the next bit.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            out_sh_q <= `AST_CODE_RESET;
        end
        else if (conv_done)
        begin
            out_sh_q <= samp_q; // [R13]
        end
        else if (!sel_on_q)
        begin
            out_sh_q <= result_q;
        end
        else if (ck_fall && bit_cnt_q != 5'h00 && bit_cnt_q <= `AST_LAST_SHIFT)
        begin
            out_sh_q <= {out_sh_q[8:0], 1'b0}; // [R13]
        end
    end

    assign link.dout     = out_sh_q[9];
    assign link.dout_oe  = sel_on_q;
    assign link.eoc      = eoc_q;
    assign sample_active = acq_q;
    assign sample_chan   = chan_q;
    assign conv_busy     = conv_q;
    assign result        = result_q;
    assign result_valid  = result_valid_q;

endmodule

`default_nettype wire

// >>> core/ast_host.sv
// Host end: makes the shift clock by division, frames transfers, returns results.
// Assumes the converter end sits on the other side of the link interface.
`timescale 1ns/10ps
`default_nettype none
`include "ast_defines.svh"

module ast_host
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    ast_link_if.host                link,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire ast_pkg::ast_chan_t cmd_chan,
    input  wire logic         [4:0] cmd_len,
    input  wire logic               cmd_framed,
    output logic                    rsp_valid,
    output ast_pkg::ast_code_t      rsp_data
);

    ast_pkg::ast_host_st_t     state_q;
    logic               [4:0]  len_q;
    logic               [4:0]  len_pick;
    logic                      framed_q;
    ast_pkg::ast_chan_t        chan_sh_q;
    logic               [7:0]  tmr_q;
    logic                      tmr_end;
    logic                      io_clk_q;
    logic                      cs_b_q;
    logic                      addr_q;
    logic               [4:0]  nclk_q;
    ast_pkg::ast_code_t        rx_q;
    logic                      rsp_valid_q;
    ast_pkg::ast_code_t        rsp_data_q;
    logic                      eoc_s1_q;
    logic                      eoc_s2_q;
    logic                      dout_s1_q;
    logic                      dout_s2_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            eoc_s1_q  <= 1'b1;
            eoc_s2_q  <= 1'b1;
            dout_s1_q <= 1'b0;
            dout_s2_q <= 1'b0;
        end
        else
        begin
            eoc_s1_q  <= link.eoc;
            eoc_s2_q  <= eoc_s1_q;
            dout_s1_q <= link.dout;
            dout_s2_q <= dout_s1_q;
        end
    end

    // Unframed frames are ten or sixteen clocks; framed ones eleven to sixteen.
    always_comb
    begin
        if (!cmd_framed)
        begin
            len_pick = (cmd_len == `AST_LEN_PLAIN) ? `AST_LEN_PLAIN : `AST_LEN_MAX; // [R4] [R8]
        end
        else if (cmd_len < `AST_LEN_MIN)
        begin
            len_pick = `AST_LEN_MIN; // [R5]
        end
        else if (cmd_len > `AST_LEN_MAX)
        begin
            len_pick = `AST_LEN_MAX; // [R5]
        end
        else
        begin
            len_pick = cmd_len;
        end
    end

    assign tmr_end = (state_q == ast_pkg::AST_H_SHIFT) ? (tmr_q == 8'(`AST_IOCLK_HALF - 1))
                                                     : (tmr_q == 8'(`AST_CS_ON_CYC + `AST_SYNC_SLACK));

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_q     <= ast_pkg::AST_H_IDLE;
            len_q       <= `AST_LEN_PLAIN;
            framed_q    <= 1'b0;
            chan_sh_q   <= 4'h0;
            tmr_q       <= 8'h00;
            io_clk_q    <= 1'b0;
            cs_b_q      <= 1'b1;
            addr_q      <= 1'b0;
            nclk_q      <= 5'h00;
            rx_q        <= `AST_CODE_RESET;
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= `AST_CODE_RESET;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            tmr_q       <= tmr_q + 8'h01;
            unique case (state_q)
                ast_pkg::AST_H_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        len_q     <= len_pick;
                        framed_q  <= cmd_framed;
                        chan_sh_q <= cmd_chan;
                        state_q   <= ast_pkg::AST_H_WAITEOC;
                    end
                end
                ast_pkg::AST_H_WAITEOC:
                begin
                    // Waiting for the flag keeps clear of both the busy converter and the abort window.
                    if (eoc_s2_q && tmr_q >= 8'(`AST_SYNC_SLACK + 4))
                    begin
                        tmr_q  <= 8'h00;
                        nclk_q <= 5'h00;
                        addr_q <= chan_sh_q[3]; // [R13]
                        if (cs_b_q)
                        begin
                            cs_b_q  <= 1'b0;
                            state_q <= ast_pkg::AST_H_SETUP; // [R6] [R12]
                        end
                        else
                        begin
                            state_q <= ast_pkg::AST_H_SHIFT; // [R6] [R12]
                        end
                    end
                end
                ast_pkg::AST_H_SETUP:
                begin
                    if (tmr_end)
                    begin
                        tmr_q   <= 8'h00;
                        state_q <= ast_pkg::AST_H_SHIFT; // [R2]
                    end
                end
                ast_pkg::AST_H_SHIFT:
                begin
                    if (tmr_end && !io_clk_q)
                    begin
                        tmr_q    <= 8'h00;
                        io_clk_q <= 1'b1; // [R7]
                        nclk_q   <= nclk_q + 5'h01;
                    end
                    else if (tmr_end)
                    begin
                        tmr_q     <= 8'h00;
                        io_clk_q  <= 1'b0;
                        chan_sh_q <= {chan_sh_q[2:0], 1'b0};
                        addr_q    <= chan_sh_q[2]; // [R13]
                        if (nclk_q <= `AST_LEN_PLAIN)
                        begin
                            rx_q <= {rx_q[8:0], dout_s2_q}; // [R13]
                        end
                        if (nclk_q == len_q)
                        begin
                            addr_q <= 1'b0;
                            if (framed_q)
                            begin
                                cs_b_q  <= 1'b1; // [R5]
                                state_q <= ast_pkg::AST_H_RELEASE;
                            end
                            else
                            begin
                                rsp_valid_q <= 1'b1;
                                rsp_data_q  <= (nclk_q <= `AST_LEN_PLAIN) ? {rx_q[8:0], dout_s2_q} : rx_q;
                                state_q     <= ast_pkg::AST_H_IDLE; // [R4] [R8]
                            end
                        end
                    end
                end
                ast_pkg::AST_H_RELEASE:
                begin
                    if (tmr_end)
                    begin
                        rsp_valid_q <= 1'b1;
                        rsp_data_q  <= rx_q;
                        state_q     <= ast_pkg::AST_H_IDLE;
                    end
                end
            endcase
        end
    end

    assign cmd_ready   = (state_q == ast_pkg::AST_H_IDLE);
    assign link.cs_b   = cs_b_q;
    assign link.io_clk = io_clk_q;
    assign link.addr   = addr_q;
    assign rsp_valid   = rsp_valid_q;
    assign rsp_data    = rsp_data_q;

endmodule

`default_nettype wire

// >>> test/ast_link_assertions.sv
// Concurrent checks on the serial link between host end and converter end.
// Assumes plain link signals plus the shared system clock and its synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module ast_link_assertions
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic io_clk,
    input wire logic addr,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic eoc
);
    logic [9:0]  sel_low_n_q;
    logic [3:0]  io_age_q;
    logic [4:0]  fall_n_q;
    logic [11:0] eoc_low_n_q;
    logic        io_q;
    logic        eoc_q;

    // Counts consecutive cycles with select low.
    always_ff @(posedge clk)
    begin
        if (!rst_b || cs_b)
            sel_low_n_q <= 10'h000;
        else if (sel_low_n_q != 10'h3FF)
            sel_low_n_q <= sel_low_n_q + 10'h001;
    end

    // Tracks shift clock falls: age of the last one and count within the frame.
    always_ff @(posedge clk)
    begin
        io_q  <= io_clk;
        eoc_q <= eoc;
        if (io_q && !io_clk)
            io_age_q <= 4'h0;
        else if (io_age_q != 4'hF)
            io_age_q <= io_age_q + 4'h1;
        if (!rst_b || cs_b || (eoc && !eoc_q))
            fall_n_q <= 5'h00;
        else if (io_q && !io_clk)
            fall_n_q <= fall_n_q + 5'h01;
        if (eoc)
            eoc_low_n_q <= 12'h000;
        else
            eoc_low_n_q <= eoc_low_n_q + 12'h001;
    end

    a_reset_idle_pins: assert property (@(posedge clk) !rst_b |=> eoc && !dout_oe)
        else $error("link pins not idle after reset");
    a_oe_after_filter: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(dout_oe) |-> !cs_b && sel_low_n_q >= 10'd143)
        else $error("output enabled before select filter time");
    a_oe_off_release: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cs_b) |-> ##[1:150] !dout_oe)
        else $error("output still enabled after select release");
    a_setup_before_clk: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(io_clk) && fall_n_q == 5'h00) |-> sel_low_n_q >= 10'd145)
        else $error("shift clock before select setup");
    a_first_clk_ready: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(io_clk) && fall_n_q == 5'h00) |-> eoc)
        else $error("frame started during conversion");
    a_eoc_tenth_fall: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(eoc) |-> fall_n_q == 5'h0A && io_age_q <= 4'h6)
        else $error("conversion flag fell away from tenth fall");
    a_conv_length: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(eoc) |-> eoc_low_n_q inside {[12'd2096:12'd2104]})
        else $error("conversion length wrong");
    a_frame_len: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cs_b) |-> (fall_n_q + 5'(io_q && !io_clk)) inside {[5'h0B:5'h10]})
        else $error("framed transfer length outside range");
    a_clk_in_frame: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(io_clk) |-> !cs_b && dout_oe)
        else $error("shift clock outside an active frame");
    a_addr_steady: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(addr) |-> !io_clk)
        else $error("address changed while shift clock high");
    a_dout_timing: assert property (@(posedge clk) disable iff (!rst_b)
        ($changed(dout) && dout_oe) |-> io_age_q <= 4'h6 || $rose(eoc))
        else $error("data output changed away from its events");
endmodule

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench: host and converter joined by one link, a second converter driven directly.
// Assumes a 100 MHz system clock shared by all ends.
`timescale 1ns/10ps
`default_nettype none
`include "ast_defines.svh"

module tb_top;
    logic               clk;
    logic               rst_b;
    logic               cmd_valid;
    logic               cmd_ready;
    ast_pkg::ast_chan_t cmd_chan;
    logic         [4:0] cmd_len;
    logic               cmd_framed;
    logic               rsp_valid;
    ast_pkg::ast_code_t rsp_data;
    ast_pkg::ast_code_t sample_level;
    logic               sample_active;
    ast_pkg::ast_chan_t sample_chan;
    logic               conv_busy;
    ast_pkg::ast_code_t result;
    logic               result_valid;
    logic               conv_busy_b;
    logic               result_valid_b;
    integer             fail_count;
    integer             checks;
    integer             seed;
    integer             acq_n;
    integer             rv_b_n;
    integer             i;
    ast_pkg::ast_code_t prev;
    ast_pkg::ast_code_t exp_q[$];

    ast_link_if link();
    ast_link_if link_b();

    ast_host ast_host_inst (.clk(clk), .rst_b(rst_b), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_chan(cmd_chan), .cmd_len(cmd_len), .cmd_framed(cmd_framed), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    ast_dev ast_dev_inst (.clk(clk), .rst_b(rst_b), .link(link), .sample_level(sample_level),
        .sample_active(sample_active), .sample_chan(sample_chan), .conv_busy(conv_busy), .result(result),
        .result_valid(result_valid));
    ast_dev ast_dev_inst_b (.clk(clk), .rst_b(rst_b), .link(link_b), .sample_level(10'h155),
        .sample_active(), .sample_chan(), .conv_busy(conv_busy_b), .result(), .result_valid(result_valid_b));
    ast_link_assertions ast_link_assertions_inst (.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b),
        .io_clk(link.io_clk), .addr(link.addr), .dout(link.dout), .dout_oe(link.dout_oe), .eoc(link.eoc));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
        checks++;
        if (seen !== expd)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, expd, seen);
        end
    endtask

    task give_verdict;
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task time_out(input string name);
        $display("Error %s wait ran out", name);
        fail_count++;
        give_verdict;
    endtask

    function automatic ast_pkg::ast_code_t exp_code(input ast_pkg::ast_chan_t ch, input ast_pkg::ast_code_t lv);
        case (ch)
            `AST_TEST_MID:  return `AST_CODE_MID;
            `AST_TEST_ZERO: return `AST_CODE_ZERO;
            `AST_TEST_FULL: return `AST_CODE_FULL;
            default:        return lv;
        endcase
    endfunction

    // One host command; the answer carries the previous conversion's code.
    task run_cmd(input ast_pkg::ast_chan_t ch, input logic [4:0] len, input logic fr);
        integer n;
        n = 0;
        while (exp_q.size() != 0)
        begin
            @(negedge clk);
            n++;
            if (n > 3000)
                time_out("result_valid");
        end
        @(negedge clk);
        sample_level = ast_pkg::ast_code_t'($random(seed));
        exp_q.push_back(exp_code(ch, sample_level));
        cmd_chan   = ch;
        cmd_len    = len;
        cmd_framed = fr;
        cmd_valid  = 1'b1;
        n = 0;
        @(posedge clk);
        while (cmd_ready !== 1'b1)
        begin
            n++;
            if (n > 20)
                time_out("cmd_ready");
            @(posedge clk);
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 9000)
                time_out("rsp_valid");
        end
        check("rsp_data", rsp_data, prev);
        prev = exp_code(ch, sample_level);
    endtask

    // Second converter: select glitch, conversion start, early select fall.
    task abort_scenario;
        @(negedge clk);
        link_b.cs_b = 1'b0;
        repeat (100) @(negedge clk);
        link_b.cs_b = 1'b1;
        repeat (60) @(negedge clk);
        check("glitch dout_oe", link_b.dout_oe, 1'b0);
        repeat (200) @(negedge clk);
        link_b.cs_b = 1'b0;
        repeat (160) @(negedge clk);
        check("dout_oe on", link_b.dout_oe, 1'b1);
        repeat (10)
        begin
            link_b.io_clk = 1'b1;
            repeat (8) @(negedge clk);
            link_b.io_clk = 1'b0;
            repeat (8) @(negedge clk);
        end
        repeat (10) @(negedge clk);
        check("conv start eoc", link_b.eoc, 1'b0);
        link_b.cs_b = 1'b1;
        repeat (160) @(negedge clk);
        check("dout_oe off", link_b.dout_oe, 1'b0);
        link_b.cs_b = 1'b0;
        repeat (200) @(negedge clk);
        check("abort eoc", link_b.eoc, 1'b1);
        check("abort busy", conv_busy_b, 1'b0);
        check("abort result", rv_b_n, 0);
    endtask

    always @(posedge clk)
    begin
        if (result_valid === 1'b1)
            check("result", result, exp_q.pop_front());
        if (sample_active === 1'b1 && acq_n == 0)
            check("sample_chan", sample_chan, cmd_chan);
        if (sample_active === 1'b1)
            acq_n <= acq_n + 1;
        else if (acq_n != 0)
        begin
            check("acquisition cycles", acq_n, 96);
            acq_n <= 0;
        end
        if (result_valid_b === 1'b1)
            rv_b_n <= rv_b_n + 1;
    end

    initial
    begin
        seed = 32'h644d0a6c;
        fail_count = 0;
        checks = 0;
        acq_n = 0;
        rv_b_n = 0;
        prev = `AST_CODE_RESET;
        rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd_chan = 4'h0;
        cmd_len = 5'h00;
        cmd_framed = 1'b0;
        sample_level = 10'h000;
        link_b.cs_b = 1'b1;
        link_b.io_clk = 1'b0;
        link_b.addr = 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check("cs_b idle", link.cs_b, 1'b1);
        check("eoc idle", link.eoc, 1'b1);
        fork
            begin
                for (i = 0; i < 3; i++)
                    run_cmd(ast_pkg::ast_chan_t'(4'hB + i), 5'h10, 1'b1);
                run_cmd(4'h3, 5'h0B, 1'b1);
                run_cmd(4'h5, 5'h02, 1'b1);
                run_cmd(4'h6, 5'h1F, 1'b1);
                for (i = 0; i < 6; i++)
                    run_cmd(ast_pkg::ast_chan_t'($random(seed)), 5'(11 + {$random(seed)} % 6), 1'b1);
                for (i = 0; i < 4; i++)
                    run_cmd(ast_pkg::ast_chan_t'($random(seed)), i[0] ? 5'h10 : 5'h0A, 1'b0);
            end
            abort_scenario;
        join
        i = 0;
        while (exp_q.size() != 0 && i < 3000)
        begin
            @(posedge clk);
            i++;
        end
        check("results left", exp_q.size(), 0);
        give_verdict;
    end
endmodule

`default_nettype wire
